// ===== pbi_pkg.sv
package pbi_pkg;
	localparam int ADDR_W = 64;
	localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;
	localparam logic [1:0] WAIT_DEFAULT = 2'h0;
	typedef enum logic [2:0] {
		PBI_IDLE = 3'b000,
		PBI_ADDR = 3'b001,
		PBI_WAIT = 3'b010,
		PBI_ACK = 3'b011,
		PBI_SNOOP = 3'b100,
		PBI_TAIL = 3'b101
	} pbi_state_t;
endpackage : pbi_pkg

// ===== pbi_top.sv
`timescale 1ns/1ns
// Operation
// - Plain and alternate requests both grant buses
// - Alternate grant waits for alternate bus free
// - Alternate grant held while alternate request stays
// - Sequence lock keeps grant while asserted
// - Grant processor at reset, dirty snoop, idle unless other master requests
// - Address strobe latches address, starts cycle
// - Group latch on processor strobe or snoop
// - Group ack from snoop ack or slave ready
// - Processor hold inserts wait states
// - Group hold; ack drops one clock after
// - Ack without hold means data done
// - Dirty snoop hit aborts requesting master
// - Cacheable only for main memory outside ranges
// - Buffer mode latches bus on clock enable
// - Buffer mode drives bus on output enable
// - Outside buffer mode, drive bus only snoop address, read data
module pbi_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Arbitration
	input wire logic proc_plain_request_n_in,
	input wire logic proc_alternate_request_n_in,
	input wire logic seq_lock_n_in,
	input wire logic other_master_req_in,
	input wire logic alt_bus_free_in,
	output logic grant_n_out,
	output logic abort_master_out,
	// Cycle control
	input wire logic addr_latch_n_in,
	input wire logic proc_transfer_ack_n_in,
	input wire logic proc_transfer_hold_n_in,
	input wire logic dirty_line_hit_n_in,
	input wire logic snoop_start_in,
	input wire logic [63:0] snoop_addr_in,
	input wire logic slave_ready_in,
	input wire logic slave_wait_in,
	input wire logic slave_main_mem_in,
	input wire logic noncacheable_hit_in,
	input wire logic proc_read_in,
	input wire logic [63:0] read_data_in,
	output logic group_address_latch_out,
	output logic group_transfer_ack_out,
	output logic group_transfer_hold_out,
	output logic burst_cacheable_enable_out,
	output logic cycle_start_out,
	output logic [63:0] cycle_addr_out,
	output logic [63:0] write_data_out,
	// Multiplexed bus and transceiver emulation
	input wire logic integrated_buffer_select_in,
	input wire logic transceiver_clock_enable_n_in,
	input wire logic transceiver_output_enable_n_in,
	input wire logic [63:0] proc_addr_data_bus_in,
	output logic [63:0] proc_addr_data_bus_out,
	output logic proc_addr_data_bus_oe_out
);
	pbi_pkg::pbi_state_t state, next_state;
	logic grant, next_grant;
	logic alt_lock, next_alt_lock;
	logic abort, next_abort;
	logic group_address_latch, next_group_address_latch;
	logic gack, next_gack;
	logic ghold, next_ghold;
	logic gbl, next_gbl;
	logic cstart, next_cstart;
	logic snooping, next_snooping;
	logic [63:0] addr, next_addr;
	logic [63:0] wdata, next_wdata;
	logic [63:0] dout, next_dout;
	logic oe, next_oe;
	logic plain_req, alt_req, lock, ale, proc_transfer_ack, proc_transfer_hold, dcl, transceiver_clock_enable, transceiver_output_enable;

	// All pins active low except rst_n_in are sampled as synchronous levels
	assign plain_req = ~proc_plain_request_n_in;
	assign alt_req = ~proc_alternate_request_n_in;
	assign lock = ~seq_lock_n_in;
	assign ale = ~addr_latch_n_in;
	assign proc_transfer_ack = ~proc_transfer_ack_n_in;
	assign proc_transfer_hold = ~proc_transfer_hold_n_in;
	assign dcl = ~dirty_line_hit_n_in;
	assign transceiver_clock_enable = ~transceiver_clock_enable_n_in;
	assign transceiver_output_enable = ~transceiver_output_enable_n_in;

	// Arbitration
	always_comb
	begin
		next_grant = grant;
		next_alt_lock = alt_lock;
		next_abort = 1'b0;
		if (snooping && dcl)
		begin
			next_abort = 1'b1;
			next_grant = 1'b1;
		end
		else if (alt_lock && alt_req)
			next_grant = 1'b1;
		else if (grant && lock)
			next_grant = 1'b1;
		else if (state == pbi_pkg::PBI_IDLE)
		begin
			next_alt_lock = 1'b0;
			if (alt_req)
			begin
				// Alternate bus must be free before granting
				next_grant = alt_bus_free_in;
				next_alt_lock = alt_bus_free_in;
			end
			else if (plain_req)
				next_grant = 1'b1;
			else
				next_grant = ~other_master_req_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			grant <= 1'b1;
			alt_lock <= 1'b0;
			abort <= 1'b0;
		end
		else
		begin
			grant <= next_grant;
			alt_lock <= next_alt_lock;
			abort <= next_abort;
		end
	end

	// Cycle control
	always_comb
	begin
		next_state = state;
		next_group_address_latch = 1'b0;
		next_gack = gack;
		next_ghold = ghold;
		next_gbl = gbl;
		next_cstart = 1'b0;
		next_snooping = snooping;
		next_addr = addr;
		next_wdata = wdata;
		next_dout = dout;
		next_oe = 1'b0;
		unique case (state)
			pbi_pkg::PBI_IDLE:
			begin
				next_gack = 1'b0;
				next_ghold = 1'b0;
				if (ale)
				begin
					next_addr = proc_addr_data_bus_in;
					next_cstart = 1'b1;
					next_group_address_latch = 1'b1;
					next_state = pbi_pkg::PBI_ADDR;
				end
				else if (snoop_start_in)
				begin
					next_group_address_latch = 1'b1;
					next_snooping = 1'b1;
					next_dout = snoop_addr_in;
					next_oe = 1'b1;
					next_state = pbi_pkg::PBI_SNOOP;
				end
			end
			pbi_pkg::PBI_ADDR:
			begin
				if (slave_ready_in)
				begin
					next_gack = 1'b1;
					next_ghold = slave_wait_in | proc_transfer_hold;
					next_state = (slave_wait_in | proc_transfer_hold) ? pbi_pkg::PBI_WAIT : pbi_pkg::PBI_ACK;
					// Only main memory outside ranges may burst or cache
					next_gbl = slave_main_mem_in & ~noncacheable_hit_in;
					if (proc_read_in)
					begin
						next_dout = read_data_in;
						next_oe = 1'b1;
					end
					else
						next_wdata = proc_addr_data_bus_in;
				end
			end
			pbi_pkg::PBI_WAIT:
			begin
				next_oe = oe;
				if (!(slave_wait_in | proc_transfer_hold))
				begin
					next_ghold = 1'b0;
					next_state = pbi_pkg::PBI_ACK;
					if (proc_read_in)
						next_dout = read_data_in;
					else
						next_wdata = proc_addr_data_bus_in;
				end
			end
			pbi_pkg::PBI_ACK:
			begin
				// Ack high with hold low marks data done
				next_gack = 1'b0;
				next_gbl = 1'b0;
				next_state = pbi_pkg::PBI_IDLE;
			end
			pbi_pkg::PBI_SNOOP:
			begin
				// Ack outlives a dropped hold by one clock
				next_gack = proc_transfer_ack | (ghold & gack);
				next_ghold = proc_transfer_hold;
				if (!proc_transfer_hold && gack && !proc_transfer_ack)
					next_state = pbi_pkg::PBI_TAIL;
				else if (!proc_transfer_ack && !proc_transfer_hold)
					next_state = pbi_pkg::PBI_TAIL;
			end
			pbi_pkg::PBI_TAIL:
			begin
				next_gack = 1'b0;
				next_ghold = 1'b0;
				next_snooping = 1'b0;
				next_state = pbi_pkg::PBI_IDLE;
			end
			default:
				next_state = pbi_pkg::PBI_IDLE;
		endcase
		// Emulated transceivers override normal bus capture and drive
		if (integrated_buffer_select_in)
		begin
			if (transceiver_clock_enable)
				next_wdata = proc_addr_data_bus_in;
			next_oe = transceiver_output_enable;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= pbi_pkg::PBI_IDLE;
			group_address_latch <= 1'b0;
			gack <= 1'b0;
			ghold <= 1'b0;
			gbl <= 1'b0;
			cstart <= 1'b0;
			snooping <= 1'b0;
			addr <= pbi_pkg::ADDR_RESET;
			wdata <= pbi_pkg::ADDR_RESET;
			dout <= pbi_pkg::ADDR_RESET;
			oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			group_address_latch <= next_group_address_latch;
			gack <= next_gack;
			ghold <= next_ghold;
			gbl <= next_gbl;
			cstart <= next_cstart;
			snooping <= next_snooping;
			addr <= next_addr;
			wdata <= next_wdata;
			dout <= next_dout;
			oe <= next_oe;
		end
	end

	assign grant_n_out = ~grant;
	assign abort_master_out = abort;
	assign group_address_latch_out = group_address_latch;
	assign group_transfer_ack_out = gack;
	assign group_transfer_hold_out = ghold;
	assign burst_cacheable_enable_out = gbl;
	assign cycle_start_out = cstart;
	assign cycle_addr_out = addr;
	assign write_data_out = wdata;
	assign proc_addr_data_bus_out = integrated_buffer_select_in ? wdata : dout;
	assign proc_addr_data_bus_oe_out = oe;

	property p_ale_group_address_latch;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ale && state == pbi_pkg::PBI_IDLE) |=> group_address_latch && cstart;
	endproperty
	a_ale_group_address_latch: assert property (p_ale_group_address_latch) else $error("no latch after strobe");
	property p_addr;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ale && state == pbi_pkg::PBI_IDLE) |=> addr == $past(proc_addr_data_bus_in);
	endproperty
	a_addr: assert property (p_addr) else $error("address not captured");
	property p_dcl;
		@(posedge clk_in) disable iff (!rst_n_in)
		(snooping && dcl) |=> abort && grant;
	endproperty
	a_dcl: assert property (p_dcl) else $error("dirty hit not handled");
	property p_gbl;
		@(posedge clk_in) disable iff (!rst_n_in)
		gbl |-> !(state == pbi_pkg::PBI_IDLE);
	endproperty
	a_gbl: assert property (p_gbl) else $error("cacheable outside access");
	property p_ack_tail;
		@(posedge clk_in) disable iff (!rst_n_in)
		(gack && $fell(ghold) && !snooping) |-> gack ##1 !gack;
	endproperty
	a_ack_tail: assert property (p_ack_tail) else $error("ack not dropped after hold");
	property p_alt;
		@(posedge clk_in) disable iff (!rst_n_in)
		(alt_lock && alt_req && !(snooping && dcl)) |=> grant;
	endproperty
	a_alt: assert property (p_alt) else $error("alternate lock lost");
	property p_lock;
		@(posedge clk_in) disable iff (!rst_n_in)
		(grant && lock) |=> grant;
	endproperty
	a_lock: assert property (p_lock) else $error("grant dropped under lock");
	property p_oe;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!integrated_buffer_select_in && oe) |-> (snooping || proc_read_in);
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven wrongly");
	property p_buf;
		@(posedge clk_in) disable iff (!rst_n_in)
		(integrated_buffer_select_in && transceiver_clock_enable) |=> wdata == $past(proc_addr_data_bus_in);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer latch missed");
	c_cycle: cover property (@(posedge clk_in) disable iff (!rst_n_in) ale ##[1:4] gack);
	c_snoop: cover property (@(posedge clk_in) disable iff (!rst_n_in) snooping && dcl);
	c_wait: cover property (@(posedge clk_in) disable iff (!rst_n_in) ghold && gack);
endmodule : pbi_top

// ===== pbi_proc_model.sv
`timescale 1ns/1ns
module pbi_proc_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Bench control
	input wire logic go_in,
	input wire logic [63:0] addr_in,
	// Controller side
	input wire logic grant_n_in,
	output logic req_n_out,
	output logic ale_n_out,
	output logic [63:0] bus_out
);
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			req_n_out <= 1'h1;
			ale_n_out <= 1'h1;
			bus_out <= 64'h0;
		end
		else
		begin
			ale_n_out <= 1'h1;
			// Idle bus toggles so stale data never looks valid
			bus_out <= ~bus_out;
			if (go_in)
				req_n_out <= 1'h0;
			else if (!req_n_out && !grant_n_in)
			begin
				req_n_out <= 1'h1;
				ale_n_out <= 1'h0;
				bus_out <= addr_in;
			end
		end
	end
endmodule : pbi_proc_model

// ===== tb_pbi_top.sv
`timescale 1ns/1ns
module tb_pbi_top;
	logic clk_in = 0, rst_n_in = 0, go = 0, proc_plain_request_n_in, addr_latch_n_in;
	logic proc_alternate_request_n_in = 1, seq_lock_n_in = 1, other_master_req_in = 0;
	logic alt_bus_free_in = 1, proc_transfer_ack_n_in = 1, proc_transfer_hold_n_in = 1;
	logic dirty_line_hit_n_in = 1, snoop_start_in = 0, slave_ready_in = 0, slave_wait_in = 0;
	logic slave_main_mem_in = 0, noncacheable_hit_in = 0, proc_read_in = 0;
	logic integrated_buffer_select_in = 0, transceiver_clock_enable_n_in = 1;
	logic transceiver_output_enable_n_in = 1;
	logic [63:0] snoop_addr_in = 64'h0, read_data_in = 64'h0, addr = 64'h0;
	logic [63:0] proc_addr_data_bus_in, proc_addr_data_bus_out;
	logic grant_n_out, abort_master_out, group_address_latch_out, group_transfer_ack_out;
	logic group_transfer_hold_out, burst_cacheable_enable_out, cycle_start_out;
	logic proc_addr_data_bus_oe_out;
	logic [63:0] cycle_addr_out, write_data_out;
	int err_count = 0, n_tests = 0;
	pbi_top i_pbi_top (.clk_in, .rst_n_in, .proc_plain_request_n_in,
		.proc_alternate_request_n_in, .seq_lock_n_in, .other_master_req_in, .alt_bus_free_in,
		.grant_n_out, .abort_master_out, .addr_latch_n_in, .proc_transfer_ack_n_in,
		.proc_transfer_hold_n_in, .dirty_line_hit_n_in, .snoop_start_in, .snoop_addr_in,
		.slave_ready_in, .slave_wait_in, .slave_main_mem_in, .noncacheable_hit_in,
		.proc_read_in, .read_data_in, .group_address_latch_out, .group_transfer_ack_out,
		.group_transfer_hold_out, .burst_cacheable_enable_out, .cycle_start_out,
		.cycle_addr_out, .write_data_out, .integrated_buffer_select_in,
		.transceiver_clock_enable_n_in, .transceiver_output_enable_n_in,
		.proc_addr_data_bus_in, .proc_addr_data_bus_out, .proc_addr_data_bus_oe_out);
	pbi_proc_model i_pbi_proc_model (.clk_in, .rst_n_in, .go_in(go), .addr_in(addr),
		.grant_n_in(grant_n_out), .req_n_out(proc_plain_request_n_in),
		.ale_n_out(addr_latch_n_in), .bus_out(proc_addr_data_bus_in));
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	task wrap_up;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait for a flag; running out ends the run
	task automatic await(input string nm, ref logic f, input logic v);
		int k;
		k = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		while (f !== v && k < 20);
		chk(nm, {63'h0, v}, {63'h0, f});
		if (f !== v)
			wrap_up();
	endtask : await
	task run_cycle(input logic [63:0] a, input logic rd, input logic wt, input logic ph,
		input logic mm, input logic nc);
		addr <= a;
		go <= 1'h1;
		@(posedge clk_in);
		go <= 1'h0;
		await("group_address_latch", group_address_latch_out, 1'h1);
		chk("cstart", 64'h1, {63'h0, cycle_start_out});
		chk("caddr", a, cycle_addr_out);
		@(posedge clk_in);
		{slave_ready_in, slave_wait_in, slave_main_mem_in, noncacheable_hit_in} <= {1'h1, wt, mm, nc};
		proc_transfer_hold_n_in <= ~ph;
		proc_read_in <= rd;
		read_data_in <= {$urandom, $urandom};
		@(posedge clk_in);
		slave_ready_in <= 1'h0;
		#1;
		chk("gack", 64'h1, {63'h0, group_transfer_ack_out});
		chk("bce", {63'h0, mm & ~nc}, {63'h0, burst_cacheable_enable_out});
		chk("ghold", {63'h0, wt | ph}, {63'h0, group_transfer_hold_out});
		if (wt | ph)
		begin
			slave_wait_in <= 1'h0;
			proc_transfer_hold_n_in <= 1'h1;
			await("hold_low", group_transfer_hold_out, 1'h0);
			chk("gack_tail", 64'h1, {63'h0, group_transfer_ack_out});
		end
		chk("oe_rd", {63'h0, rd}, {63'h0, proc_addr_data_bus_oe_out});
		// The partner toggles its idle bus, so the captured word is the inverse of the current one
		if (rd)
			chk("rdata", read_data_in, proc_addr_data_bus_out);
		else
			chk("wdata", ~proc_addr_data_bus_in, write_data_out);
		@(posedge clk_in);
		#1;
		chk("gack_end", 64'h0, {63'h0, group_transfer_ack_out});
	endtask : run_cycle
	// Arbitration inputs are {alternate request_n, alternate bus free, lock_n, other master}
	task arb_step(input logic [3:0] v, input logic e);
		@(posedge clk_in);
		{proc_alternate_request_n_in, alt_bus_free_in, seq_lock_n_in, other_master_req_in} <= v;
		@(posedge clk_in);
		#1;
		chk("grant_n", {63'h0, e}, {63'h0, grant_n_out});
	endtask : arb_step
	initial
	begin
		void'($urandom(32'hACF2C686));
		repeat (16) @(posedge clk_in);
		chk("grant_rst", 64'h0, {63'h0, grant_n_out});
		rst_n_in <= 1'h1;
		@(posedge clk_in);
		#1;
		chk("oe_idle", 64'h0, {63'h0, proc_addr_data_bus_oe_out});
		run_cycle(64'hFFFF_FFFF_FFFF_FFFF, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
		run_cycle(64'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
		run_cycle(64'h5, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
		repeat (12)
			run_cycle({$urandom, $urandom}, 1'($urandom), 1'($urandom), 1'($urandom),
				1'($urandom), 1'($urandom));
		arb_step(4'hB, 1'h1);
		arb_step(4'h3, 1'h1);
		arb_step(4'h7, 1'h0);
		arb_step(4'h3, 1'h0);
		arb_step(4'h9, 1'h0);
		arb_step(4'hB, 1'h1);
		@(posedge clk_in);
		snoop_start_in <= 1'h1;
		snoop_addr_in <= {$urandom, $urandom};
		@(posedge clk_in);
		snoop_start_in <= 1'h0;
		{proc_transfer_ack_n_in, dirty_line_hit_n_in} <= 2'h0;
		#1;
		chk("group_address_latch_snoop", 64'h1, {63'h0, group_address_latch_out});
		chk("oe_snoop", 64'h1, {63'h0, proc_addr_data_bus_oe_out});
		chk("snoop_addr", snoop_addr_in, proc_addr_data_bus_out);
		await("abort", abort_master_out, 1'h1);
		{proc_transfer_ack_n_in, dirty_line_hit_n_in} <= 2'h3;
		chk("gack_snoop", 64'h1, {63'h0, group_transfer_ack_out});
		chk("grant_dirty", 64'h0, {63'h0, grant_n_out});
		integrated_buffer_select_in <= 1'h1;
		transceiver_output_enable_n_in <= 1'h0;
		transceiver_clock_enable_n_in <= 1'h0;
		await("oe_buf", proc_addr_data_bus_oe_out, 1'h1);
		chk("buf_latch", ~proc_addr_data_bus_in, write_data_out);
		chk("buf_drive", ~proc_addr_data_bus_in, proc_addr_data_bus_out);
		wrap_up();
	end
endmodule : tb_pbi_top
